// ==== testbench/rgi_link_sva.sv ====
`timescale 1ns/10ps
// ====================================================================
// Link checks between the two ends
module rgi_link_sva
  import rgi_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [3:0] gain_pulse,
  input  wire logic       reg_req,
  input  wire logic       reg_we,
  input  wire logic [9:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_ack
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Readback decode; address is still held while ack stands
  wire rd_ack = reg_ack && !reg_we;
  wire fe_rb  = (reg_addr == REG_RX1_FE_RB) || (reg_addr == REG_RX2_FE_RB);
  wire flt_rb = (reg_addr == REG_RX1_FLT_RB) || (reg_addr == REG_RX2_FLT_RB);
  wire dig_rb = (reg_addr == REG_RX1_DIG_RB) || (reg_addr == REG_RX2_DIG_RB);
  wire any_p  = |gain_pulse;
  a_ack_answer: assert property ($rose(reg_req) |=> reg_ack) else $error("ack late");
  a_ack_single: assert property (reg_ack |=> !reg_ack) else $error("ack too long");
  a_req_release: assert property (reg_ack |=> !reg_req) else $error("req kept");
  a_ack_idle: assert property (!reg_req |=> !reg_ack) else $error("ack without req");
  a_req_held: assert property (reg_req && !reg_ack |=> reg_req && $stable(reg_addr) && $stable(reg_we)
                               && $stable(reg_wdata)) else $error("req changed");
  a_pulse_high: assert property ($rose(any_p) |-> any_p [*2]) else $error("pulse short");
  a_pulse_low: assert property ($fell(any_p) |-> !any_p [*2]) else $error("gap short");
  a_fe_width: assert property (rd_ack && fe_rb |-> reg_rdata <= 8'h5A) else $error("fe above max");
  a_flt_range: assert property (rd_ack && flt_rb |-> reg_rdata <= 8'h18) else $error("flt range");
  a_dig_width: assert property (rd_ack && dig_rb |-> reg_rdata[7:5] == 3'h0) else $error("dig wide");
endmodule : rgi_link_sva

// ==== testbench/tb_top.sv ====
`timescale 1ns/10ps
// ====================================================================
// Both ends joined; bench drives APB and the detector levels
module tb_top
  import rgi_pkg::*;
;
  logic                   ref_clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata;
  logic [NUM_RX-1:0]      lmt_ovl, adc_ovl, dig_sat, pwr_vld;
  logic [NUM_RX-1:0][6:0] fe_idx, rx_pwr;
  logic [NUM_RX-1:0][4:0] flt_idx, dig_idx;
  logic [7:0]             stat_rd;
  logic [31:0]            apb_rd;
  logic                   err_rd;
  int                     errors, checked;

  rgi_if i_rgi_if ();
  rgi_bbp i_rgi_bbp (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .link(i_rgi_if));
  // Detector levels and power strobes both come from the bench
  rgi_device i_rgi_device (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .link(i_rgi_if),
    .lmt_large_ovl_i(lmt_ovl), .adc_ovl_i(adc_ovl), .dig_sat_i(dig_sat), .rx_power_i(rx_pwr),
    .rx_power_valid_i(pwr_vld), .fe_index_o(fe_idx), .flt_index_o(flt_idx), .dig_index_o(dig_idx));
  rgi_link_sva i_rgi_link_sva (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .gain_pulse(i_rgi_if.gain_pulse),
    .reg_req(i_rgi_if.reg_req), .reg_we(i_rgi_if.reg_we), .reg_addr(i_rgi_if.reg_addr),
    .reg_wdata(i_rgi_if.reg_wdata), .reg_rdata(i_rgi_if.reg_rdata), .reg_ack(i_rgi_if.reg_ack));

  // Clock
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  // ==================================================================
  // Tasks
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  // One APB transfer; request held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge ref_clk_i);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    err_rd = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      errors++;
      $display("unexpected at %0t: no pready", $time);
      end_sim();
    end
  endtask : apb

  // Poll a status bit until clear, bounded
  task automatic poll(input int b);
    logic [31:0] r;
    int          n;
    n = 0;
    do begin
      apb(1'b0, HOST_STAT, 32'h0000_0000, r);
      n++;
    end while (r[b] !== 1'b0 && n < 50);
    stat_rd = r[15:8];
    if (n >= 50) begin
      errors++;
      $display("unexpected at %0t: stuck busy", $time);
      end_sim();
    end
  endtask : poll

  task automatic dev_wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, HOST_CMD, {1'b1, 13'h0000, a, d}, r);
    poll(0);
  endtask : dev_wr

  task automatic dev_rd(input logic [9:0] a, input logic [7:0] e);
    logic [31:0] r;
    apb(1'b1, HOST_CMD, {1'b0, 13'h0000, a, 8'h00}, r);
    poll(0);
    chk(stat_rd, e);
  endtask : dev_rd

  task automatic pulse(input logic [3:0] m);
    logic [31:0] r;
    apb(1'b1, HOST_PULSE, {28'h000_0000, m}, r);
    poll(1);
  endtask : pulse

  // One power strobe on receiver one, then the frontend index compared
  task automatic strobe(input logic [6:0] p, input logic [6:0] e);
    @(posedge ref_clk_i);
    rx_pwr  <= {7'h00, p};
    pwr_vld <= 2'b01;
    @(posedge ref_clk_i);
    pwr_vld <= 2'b00;
    @(posedge ref_clk_i);
    chk({1'b0, fe_idx[0]}, {1'b0, e});
  endtask : strobe

  // ==================================================================
  // Main sequence
  initial begin
    errors = 0;
    checked = 0;
    rst_n_i = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {lmt_ovl, adc_ovl, dig_sat, pwr_vld, rx_pwr} = '0;
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    dev_rd(REG_RX1_FE_RB, 8'h00);
    dev_rd(REG_RX2_DIG_RB, 8'h00);
    $display("test reset done");
    dev_wr(REG_IDX_WR, 8'h5F);
    dev_rd(REG_RX1_FE_RB, 8'h5A);
    dev_wr(REG_FULL_MAX, 8'h32);
    dev_wr(REG_IDX_WR, 8'h3C);
    dev_rd(REG_RX1_FE_RB, 8'h32);
    chk({1'b0, fe_idx[0]}, 8'h32);
    $display("test full register done");
    // Pulse control in full table
    dev_wr(REG_MODE, 8'h04);
    pulse(4'h1);
    chk({1'b0, fe_idx[0]}, 8'h32);
    pulse(4'h2);
    chk({1'b0, fe_idx[0]}, 8'h31);
    dev_wr(REG_DEC_STEP, 8'h02);
    pulse(4'h2);
    chk({1'b0, fe_idx[0]}, 8'h2E);
    pulse(4'h4);
    chk({1'b0, fe_idx[1]}, 8'h01);
    pulse(4'h8);
    pulse(4'h8);
    chk({1'b0, fe_idx[1]}, 8'h00);
    dev_wr(REG_RX1_FE_RB, 8'h05);
    dev_rd(REG_RX1_FE_RB, 8'h2E);
    $display("test full pulse done");
    // Split table, register control, digital on
    dev_wr(REG_MODE, 8'h03);
    dev_wr(REG_DEC_STEP, 8'h00);
    dev_wr(10'h100, 8'h2D);
    dev_wr(10'h101, 8'h1E);
    dev_wr(10'h102, 8'h21);
    dev_rd(REG_RX1_FE_RB, 8'h28);
    dev_rd(REG_RX1_FLT_RB, 8'h18);
    dev_rd(REG_RX1_DIG_RB, 8'h1F);
    dev_wr(10'h104, 8'h07);
    dev_rd(REG_RX2_FLT_RB, 8'h07);
    chk({3'h0, flt_idx[0]}, 8'h18);
    $display("test split register done");
    // Split table, pulses routed by the target bit
    dev_wr(REG_MODE, 8'h07);
    dev_wr(REG_INC_STEP, 8'h10);
    pulse(4'h2);
    chk({1'b0, fe_idx[0]}, 8'h27);
    dev_wr(REG_INC_STEP, 8'h00);
    pulse(4'h2);
    chk({3'h0, flt_idx[0]}, 8'h17);
    chk({3'h0, dig_idx[0]}, 8'h1F);
    pulse(4'h1);
    pulse(4'h1);
    chk({3'h0, flt_idx[0]}, 8'h18);
    $display("test split pulse done");
    // Detector steered decrements
    dev_wr(REG_INC_STEP, 8'h08);
    lmt_ovl <= 2'b01;
    adc_ovl <= 2'b01;
    dig_sat <= 2'b01;
    pulse(4'h2);
    chk({1'b0, fe_idx[0]}, 8'h26);
    lmt_ovl <= 2'b00;
    pulse(4'h2);
    chk({1'b0, fe_idx[0]}, 8'h25);
    dev_wr(REG_IDX_WR, 8'h14);
    pulse(4'h2);
    chk({3'h0, flt_idx[0]}, 8'h17);
    adc_ovl <= 2'b00;
    pulse(4'h2);
    chk({3'h0, dig_idx[0]}, 8'h1E);
    dig_sat <= 2'b00;
    lmt_ovl <= 2'b01;
    dev_wr(REG_IDX_WR, 8'h00);
    pulse(4'h2);
    chk({3'h0, flt_idx[0]}, 8'h16);
    lmt_ovl <= 2'b00;
    pulse(4'h1);
    chk({1'b0, fe_idx[0]}, 8'h01);
    $display("test steered done");
    // Slow attack: window programmed before the loop is enabled
    dev_wr(REG_SLOW_BASE, 8'h20);
    dev_wr(10'h111, 8'h28);
    dev_wr(10'h112, 8'h04);
    dev_wr(10'h113, 8'h04);
    dev_wr(10'h114, 8'h03);
    dev_wr(10'h115, 8'h01);
    dev_wr(10'h116, 8'h01);
    dev_wr(10'h117, 8'h02);
    dev_rd(10'h112, 8'h04);
    dev_wr(REG_MODE, 8'h0D);
    dev_wr(REG_IDX_WR, 8'h14);
    strobe(7'h1A, 7'h11);
    strobe(7'h1E, 7'h10);
    strobe(7'h24, 7'h10);
    strobe(7'h2A, 7'h11);
    strobe(7'h30, 7'h13);
    pulse(4'h1);
    chk({1'b0, fe_idx[0]}, 8'h13);
    $display("test slow attack done");
    // Host side: unmapped offset flagged and read as zero
    apb(1'b0, 12'h00C, 32'h0000_0000, apb_rd);
    chk({7'h00, err_rd}, 8'h01);
    chk(apb_rd[7:0], 8'h00);
    apb(1'b0, HOST_STAT, 32'h0000_0000, apb_rd);
    chk({7'h00, err_rd}, 8'h00);
    $display("test host errors done");
    end_sim();
  end
endmodule : tb_top

// ==== verilog/rgi_bbp.sv ====
`timescale 1ns/10ps
// ====================================================================
// Baseband processor end: APB orders become register transfers and pulses
module rgi_bbp
  import rgi_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  rgi_if.bbp               link
);
  typedef enum logic [0:0] {L_IDLE, L_WAIT} rgi_link_st_t;
  typedef enum logic [1:0] {P_IDLE, P_HIGH, P_LOW} rgi_pulse_st_t;

  rgi_link_st_t  link_st_reg;
  rgi_pulse_st_t pulse_st_reg;
  logic          we_reg;
  logic [9:0]    addr_reg;
  logic [7:0]    wdata_reg;
  logic [7:0]    rdata_reg;
  logic [3:0]    pins_reg;
  logic [3:0]    pmask_reg;
  logic [3:0]    pcnt_reg;
  logic [31:0]   prdata_reg;

  // ==================================================================
  // APB decode; zero wait states
  wire acc      = psel_i & penable_i;
  wire mapped   = (paddr_i == HOST_CMD) | (paddr_i == HOST_STAT) | (paddr_i == HOST_PULSE);
  wire busy     = link_st_reg != L_IDLE;
  wire pbusy    = pulse_st_reg != P_IDLE;
  wire cmd_go   = acc & pwrite_i & (paddr_i == HOST_CMD) & ~busy;
  wire pulse_go = acc & pwrite_i & (paddr_i == HOST_PULSE) & ~pbusy & (pwdata_i[3:0] != 4'h0);
  wire [31:0] stat_word = {16'h0000, rdata_reg, 6'h00, pbusy, busy};
  wire last_cnt = pcnt_reg == 4'(PULSE_HOLD_CYC - 1);

  assign pready_o  = 1'b1;
  assign pslverr_o = acc & ~mapped;
  assign prdata_o  = prdata_reg;

  // Read data captured in the setup cycle so the access phase ends at once
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel_i & ~penable_i & ~pwrite_i) begin
      prdata_reg <= (paddr_i == HOST_STAT) ? stat_word : 32'h0000_0000;
    end
  end

  // One command is one register transfer; split indices need one each
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      link_st_reg <= L_IDLE;
      we_reg      <= 1'b0;
      addr_reg    <= 10'h000;
      wdata_reg   <= 8'h00;
      rdata_reg   <= 8'h00;
    end else begin
      case (link_st_reg)
        L_IDLE: begin
          if (cmd_go) begin
            we_reg      <= pwdata_i[31];
            addr_reg    <= pwdata_i[17:8];
            wdata_reg   <= pwdata_i[7:0];
            link_st_reg <= L_WAIT;
          end
        end
        L_WAIT: begin
          if (link.reg_ack) begin
            if (!we_reg) rdata_reg <= link.reg_rdata;
            link_st_reg <= L_IDLE;
          end
        end
        default: link_st_reg <= L_IDLE;
      endcase
    end
  end

  // Pulses held high then low for the minimum time the far end samples
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pulse_st_reg <= P_IDLE;
      pins_reg     <= 4'h0;
      pmask_reg    <= 4'h0;
      pcnt_reg     <= 4'h0;
    end else begin
      case (pulse_st_reg)
        P_IDLE: begin
          if (pulse_go) begin
            pmask_reg    <= pwdata_i[3:0];
            pins_reg     <= pwdata_i[3:0];
            pcnt_reg     <= 4'h0;
            pulse_st_reg <= P_HIGH;
          end
        end
        P_HIGH: begin
          pcnt_reg <= pcnt_reg + 4'h1;
          if (last_cnt) begin
            pins_reg     <= 4'h0;
            pcnt_reg     <= 4'h0;
            pulse_st_reg <= P_LOW;
          end
        end
        P_LOW: begin
          pcnt_reg <= pcnt_reg + 4'h1;
          if (last_cnt) pulse_st_reg <= P_IDLE;
        end
        default: pulse_st_reg <= P_IDLE;
      endcase
    end
  end

  assign link.reg_req    = link_st_reg == L_WAIT;
  assign link.reg_we     = we_reg;
  assign link.reg_addr   = addr_reg;
  assign link.reg_wdata  = wdata_reg;
  assign link.gain_pulse = pins_reg;
endmodule : rgi_bbp

// ==== verilog/rgi_device.sv ====
// The implementer's own choice: register access over a req/ack register link.
`timescale 1ns/10ps
module rgi_device
  import rgi_pkg::*;
(
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_n_i,
  rgi_if.device                            link,
  input  wire logic [NUM_RX-1:0]           lmt_large_ovl_i,
  input  wire logic [NUM_RX-1:0]           adc_ovl_i,
  input  wire logic [NUM_RX-1:0]           dig_sat_i,
  input  wire logic [NUM_RX-1:0][6:0]      rx_power_i,
  input  wire logic [NUM_RX-1:0]           rx_power_valid_i,
  output logic      [NUM_RX-1:0][6:0]      fe_index_o,
  output logic      [NUM_RX-1:0][4:0]      flt_index_o,
  output logic      [NUM_RX-1:0][4:0]      dig_index_o
);
  // ==================================================================
  // Configuration and index state
  logic [3:0] mode_reg;
  logic [6:0] full_max_reg;
  logic [6:0] fe_limit_reg;
  logic [7:0] inc_step_reg;
  logic [7:0] dec_step_reg;
  logic [7:0] ovl_step_reg;
  logic [7:0] slow_reg [8];
  logic [6:0] fe_reg  [NUM_RX];
  logic [6:0] flt_reg [NUM_RX];
  logic [6:0] dig_reg [NUM_RX];
  logic [6:0] fe_next  [NUM_RX];
  logic [6:0] flt_next [NUM_RX];
  logic [6:0] dig_next [NUM_RX];
  logic [3:0] pulse_s1_reg;
  logic [3:0] pulse_s2_reg;
  logic [3:0] pulse_s3_reg;
  logic       ack_reg;
  logic [7:0] rdata_reg;

  // ==================================================================
  // Decode
  wire        take      = link.reg_req & ~ack_reg;
  wire        wr        = take & link.reg_we;
  wire        split     = mode_reg[MODE_SPLIT_BIT];
  wire        dig_en    = mode_reg[MODE_DIG_EN_BIT];
  wire        pulse_on  = mode_reg[MODE_PULSE_BIT] & ~mode_reg[MODE_SLOW_BIT];
  wire        slow_on   = mode_reg[MODE_SLOW_BIT];
  wire        steer     = inc_step_reg[STEER_BIT];
  wire        target_fe = inc_step_reg[TARGET_BIT];
  // Step fields are stored as count minus one so a zero field still moves
  wire [6:0]  inc_step  = {4'h0, inc_step_reg[STEP_LO_POS +: 3]} + 7'h01;
  wire [6:0]  dec_step  = {4'h0, dec_step_reg[STEP_LO_POS +: 3]} + 7'h01;
  wire [6:0]  fe_ovl_st = {4'h0, dec_step_reg[STEP_HI_POS +: 3]} + 7'h01;
  wire [6:0]  flt_ovl_st = {4'h0, ovl_step_reg[STEP_LO_POS +: 3]} + 7'h01;
  wire [6:0]  dig_st    = {4'h0, ovl_step_reg[STEP_HI_POS +: 3]} + 7'h01;
  // Pointer ceiling for the frontend or combined index
  wire [6:0]  full_cap  = (full_max_reg < FULL_MAX) ? full_max_reg : FULL_MAX;
  wire [6:0]  idx_cap   = split ? SPLIT_MAX : full_cap;
  wire [6:0]  flt_cap   = (FLT_MAX < SPLIT_MAX) ? FLT_MAX : SPLIT_MAX;
  wire [3:0]  rise      = pulse_s2_reg & ~pulse_s3_reg;
  wire        in_slow   = link.reg_addr[9:3] == REG_SLOW_BASE[9:3];

  // Read selection; unmapped locations read zero
  function automatic logic [7:0] rd_sel(input logic [9:0] a);
    case (a)
      REG_MODE:       return {4'h0, mode_reg};
      REG_FULL_MAX:   return {1'b0, full_max_reg};
      REG_FE_LIMIT:   return {1'b0, fe_limit_reg};
      REG_INC_STEP:   return inc_step_reg;
      REG_DEC_STEP:   return dec_step_reg;
      REG_OVL_STEP:   return ovl_step_reg;
      REG_RX1_FE_RB:  return {1'b0, fe_reg[0]};
      REG_RX1_FLT_RB: return {3'h0, flt_reg[0][4:0]};
      REG_RX1_DIG_RB: return {3'h0, dig_reg[0][4:0]};
      REG_RX2_FE_RB:  return {1'b0, fe_reg[1]};
      REG_RX2_FLT_RB: return {3'h0, flt_reg[1][4:0]};
      REG_RX2_DIG_RB: return {3'h0, dig_reg[1][4:0]};
      default:        return (a[9:3] == REG_SLOW_BASE[9:3]) ? slow_reg[a[2:0]] : 8'h00;
    endcase
  endfunction : rd_sel

  // A process rather than an assign, so index changes behind a held address are seen
  logic [7:0] rd_val;
  always_comb begin
    rd_val = rd_sel(link.reg_addr);
  end

  // ==================================================================
  // Register port: one request taken, answered by a one-cycle ack
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= REG_RST;
    end else begin
      ack_reg   <= take;
      if (take) begin
        rdata_reg <= rd_val;
      end
    end
  end

  // Configuration writes; window has no meaningful default until written
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      mode_reg     <= 4'h0;
      full_max_reg <= FULL_MAX_RST;
      fe_limit_reg <= FE_LIMIT_RST;
      inc_step_reg <= REG_RST;
      dec_step_reg <= REG_RST;
      ovl_step_reg <= REG_RST;
      for (int i = 0; i < 8; i++) begin
        slow_reg[i] <= REG_RST;
      end
    end else if (wr) begin
      if (link.reg_addr == REG_MODE)     mode_reg     <= link.reg_wdata[3:0];
      if (link.reg_addr == REG_FULL_MAX) full_max_reg <= link.reg_wdata[6:0];
      if (link.reg_addr == REG_FE_LIMIT) fe_limit_reg <= link.reg_wdata[6:0];
      if (link.reg_addr == REG_INC_STEP) inc_step_reg <= link.reg_wdata;
      if (link.reg_addr == REG_DEC_STEP) dec_step_reg <= link.reg_wdata;
      if (link.reg_addr == REG_OVL_STEP) ovl_step_reg <= link.reg_wdata;
      if (in_slow)                       slow_reg[link.reg_addr[2:0]] <= link.reg_wdata;
    end
  end

  // Pulse pins are asynchronous: two flops, then a third for the edge
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pulse_s1_reg <= 4'h0;
      pulse_s2_reg <= 4'h0;
      pulse_s3_reg <= 4'h0;
    end else begin
      pulse_s1_reg <= link.gain_pulse;
      pulse_s2_reg <= pulse_s1_reg;
      pulse_s3_reg <= pulse_s2_reg;
    end
  end

  assign link.reg_ack   = ack_reg;
  assign link.reg_rdata = rdata_reg;

  // ==================================================================
  // Per receiver index update
  for (genvar g = 0; g < NUM_RX; g++) begin : g_rx
    wire [9:0] wr_base = REG_IDX_WR + 10'(3 * g);
    wire       wr_fe   = wr & (link.reg_addr == wr_base);
    wire       wr_flt  = wr & (link.reg_addr == wr_base + 10'h001);
    wire       wr_dig  = wr & (link.reg_addr == wr_base + 10'h002);
    wire       up_ev   = rise[2*g] & ~rise[2*g+1];
    wire       dn_ev   = rise[2*g+1] & ~rise[2*g];
    wire [7:0] pwr     = {1'b0, rx_power_i[g]};
    // Thresholds are negative dBFS, so a smaller figure is a louder signal
    wire [7:0] in_hi   = slow_reg[0];
    wire [7:0] in_lo   = slow_reg[1];
    wire       over_o  = (pwr + slow_reg[2]) < in_hi;
    wire       over_i  = pwr < in_hi;
    wire       under_o = pwr > (in_lo + slow_reg[3]);
    wire       under_i = pwr > in_lo;

    always_comb begin
      fe_next[g]  = fe_reg[g];
      flt_next[g] = flt_reg[g];
      dig_next[g] = dig_reg[g];
      if (wr_fe | wr_flt | wr_dig) begin
        // Register writes load indices directly and win over pulses
        if (wr_fe)  fe_next[g]  = (link.reg_wdata[6:0] > idx_cap) ? idx_cap : link.reg_wdata[6:0];
        if (wr_flt) flt_next[g] = (link.reg_wdata[6:0] > flt_cap) ? flt_cap : link.reg_wdata[6:0];
        if (wr_dig & dig_en) dig_next[g] = (link.reg_wdata[6:0] > DIG_MAX) ? DIG_MAX : link.reg_wdata[6:0];
      end else if (pulse_on & (up_ev | dn_ev)) begin
        if (!split) begin
          fe_next[g] = up_ev ? sat_up(fe_reg[g], inc_step, full_cap) : sat_dn(fe_reg[g], dec_step);
        end else if (!steer) begin
          // Selected analog index only; digital index left alone
          if (target_fe) fe_next[g]  = up_ev ? sat_up(fe_reg[g], inc_step, SPLIT_MAX) : sat_dn(fe_reg[g], dec_step);
          else           flt_next[g] = up_ev ? sat_up(flt_reg[g], inc_step, flt_cap) : sat_dn(flt_reg[g], dec_step);
        end else if (up_ev) begin
          fe_next[g] = sat_up(fe_reg[g], inc_step, SPLIT_MAX);
        end else if (lmt_large_ovl_i[g]) begin
          if (fe_reg[g] != 7'h00) fe_next[g]  = sat_dn(fe_reg[g], fe_ovl_st);
          else                    flt_next[g] = sat_dn(flt_reg[g], flt_ovl_st);
        end else if (adc_ovl_i[g]) begin
          if (fe_reg[g] > fe_limit_reg) fe_next[g]  = sat_dn(fe_reg[g], fe_ovl_st);
          else                          flt_next[g] = sat_dn(flt_reg[g], flt_ovl_st);
        end else if (dig_sat_i[g] & dig_en) begin
          dig_next[g] = sat_dn(dig_reg[g], dig_st);
        end else if (fe_reg[g] != 7'h00) begin
          fe_next[g] = sat_dn(fe_reg[g], dec_step);
        end else begin
          flt_next[g] = sat_dn(flt_reg[g], dec_step);
        end
      end else if (slow_on & rx_power_valid_i[g]) begin
        // Hysteresis: inside the inner window nothing moves
        if (over_o)       fe_next[g] = sat_dn(fe_reg[g], slow_reg[4][6:0]);
        else if (over_i)  fe_next[g] = sat_dn(fe_reg[g], slow_reg[5][6:0]);
        else if (under_o) fe_next[g] = sat_up(fe_reg[g], slow_reg[7][6:0], idx_cap);
        else if (under_i) fe_next[g] = sat_up(fe_reg[g], slow_reg[6][6:0], idx_cap);
      end
    end

    always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
        fe_reg[g]  <= IDX_RST;
        flt_reg[g] <= IDX_RST;
        dig_reg[g] <= IDX_RST;
      end else begin
        fe_reg[g]  <= fe_next[g];
        flt_reg[g] <= flt_next[g];
        dig_reg[g] <= dig_next[g];
      end
    end

    assign fe_index_o[g]  = fe_reg[g];
    assign flt_index_o[g] = flt_reg[g][4:0];
    assign dig_index_o[g] = dig_reg[g][4:0];
  end
endmodule : rgi_device

// ==== verilog/rgi_if.sv ====
`timescale 1ns/10ps
// ====================================================================
// Link between the baseband processor and the gain index device
interface rgi_if;
  logic [3:0] gain_pulse;  // gain_pulse_in0..3
  logic       reg_req;
  logic       reg_we;
  logic [9:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       reg_ack;

  modport device (input gain_pulse, input reg_req, input reg_we, input reg_addr, input reg_wdata,
                  output reg_rdata, output reg_ack);
  modport bbp (output gain_pulse, output reg_req, output reg_we, output reg_addr, output reg_wdata,
               input reg_rdata, input reg_ack);
endinterface : rgi_if

// ==== verilog/rgi_pkg.sv ====
// ====================================================================
// Shared constants for the receive gain index controller
package rgi_pkg;
  localparam int NUM_RX = 2;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int IDX_W  = 7;

  // ==================================================================
  // Index readback locations
  localparam logic [9:0] REG_RX1_FE_RB  = 10'h2B0;
  localparam logic [9:0] REG_RX1_FLT_RB = 10'h2B1;
  localparam logic [9:0] REG_RX1_DIG_RB = 10'h2B2;
  localparam logic [9:0] REG_RX2_FE_RB  = 10'h2B5;
  localparam logic [9:0] REG_RX2_FLT_RB = 10'h2B6;
  localparam logic [9:0] REG_RX2_DIG_RB = 10'h2B7;

  // ==================================================================
  // Configuration locations
  localparam logic [9:0] REG_MODE       = 10'h0F0;
  localparam logic [9:0] REG_FULL_MAX   = 10'h0F1;
  localparam logic [9:0] REG_FE_LIMIT   = 10'h0F2;
  localparam logic [9:0] REG_INC_STEP   = 10'h0FC;
  localparam logic [9:0] REG_DEC_STEP   = 10'h0FE;
  localparam logic [9:0] REG_OVL_STEP   = 10'h0FF;
  localparam logic [9:0] REG_IDX_WR     = 10'h100;  // Rx n: base + 3n + {fe, flt, dig}
  localparam logic [9:0] REG_SLOW_BASE  = 10'h110;  // Eight slow attack window entries

  // Mode register fields
  localparam int MODE_SPLIT_BIT  = 0;
  localparam int MODE_DIG_EN_BIT = 1;
  localparam int MODE_PULSE_BIT  = 2;
  localparam int MODE_SLOW_BIT   = 3;
  // Step register fields
  localparam int STEER_BIT       = 3;
  localparam int TARGET_BIT      = 4;
  localparam int STEP_LO_POS     = 0;
  localparam int STEP_HI_POS     = 3;

  // ==================================================================
  // Index limits and reset values
  localparam logic [6:0] FLT_MAX       = 7'h18;  // 24
  localparam logic [6:0] DIG_MAX       = 7'h1F;  // 31
  localparam logic [6:0] SPLIT_MAX     = 7'h28;  // 40
  localparam logic [6:0] FULL_MAX      = 7'h5A;  // 90
  localparam logic [6:0] FULL_MAX_RST  = 7'h5A;
  localparam logic [6:0] FE_LIMIT_RST  = 7'h14;
  localparam logic [7:0] REG_RST       = 8'h00;
  localparam logic [6:0] IDX_RST       = 7'h00;

  // ==================================================================
  // Host side map and pulse timing
  localparam logic [11:0] HOST_CMD     = 12'h000;
  localparam logic [11:0] HOST_STAT    = 12'h004;
  localparam logic [11:0] HOST_PULSE   = 12'h008;
  localparam int CLK_PERIOD_NS  = 20;
  localparam int PULSE_MIN_NS   = 40;
  // One spare cycle covers the unknown phase at the far synchroniser
  localparam int PULSE_HOLD_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;

  // Saturating index steps, never wrap
  function automatic logic [6:0] sat_up(input logic [6:0] v, input logic [6:0] s, input logic [6:0] m);
    logic [7:0] t;
    t = {1'b0, v} + {1'b0, s};
    return (t > {1'b0, m}) ? m : t[6:0];
  endfunction : sat_up

  function automatic logic [6:0] sat_dn(input logic [6:0] v, input logic [6:0] s);
    return (v > s) ? v - s : 7'h00;
  endfunction : sat_dn
endpackage : rgi_pkg
